// File: common/charger_status_pkg.sv
// Constants shared by the live charger status register bank
package charger_status_pkg;
  // Register offsets (byte addresses on the register port)
  localparam logic [7:0] CHARGE_REGULATION_STATUS_OFFSET = 8'h00;
  localparam logic [7:0] FAULT_TEMPERATURE_STATUS_OFFSET = 8'h01;
  // Value after reset (documented as undefined, zero chosen)
  localparam logic [7:0] STATUS_RESET_VALUE = 8'h00;
  // Answer for an unmapped offset
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
  // Charge-regulation status field positions
  localparam int TAPER_MODE_ACTIVE_BIT               = 6;
  localparam int CHARGE_DONE_BIT                     = 5;
  localparam int INPUT_CURRENT_LIMITING_ACTIVE_BIT   = 4;
  localparam int POWER_PATH_REGULATION_ACTIVE_BIT    = 3;
  localparam int INPUT_VOLTAGE_REGULATION_ACTIVE_BIT = 2;
  localparam int THERMAL_REGULATION_ACTIVE_BIT       = 1;
  localparam int INPUT_POWER_GOOD_BIT                = 0;
  // Fault/temperature status field positions
  localparam int INPUT_OVERVOLTAGE_ACTIVE_BIT    = 7;
  localparam int BATTERY_OVERCURRENT_ACTIVE_BIT  = 5;
  localparam int BATTERY_UNDERVOLTAGE_ACTIVE_BIT = 4;
  localparam int THERMISTOR_COLD_ZONE_BIT        = 3;
  localparam int THERMISTOR_COOL_ZONE_BIT        = 2;
  localparam int THERMISTOR_WARM_ZONE_BIT        = 1;
  localparam int THERMISTOR_HOT_ZONE_BIT         = 0;
  // Number of thermistor zones, order cold, cool, warm, hot (MSB first)
  localparam int ZONE_COUNT = 4;
  // Cycles from a condition input to its status register bit
  localparam int STATUS_LATENCY_CYCLES = 1;
  // Cycles from a read request to read data
  localparam int READ_LATENCY_CYCLES = 1;
endpackage

// File: common/thermistor_zone_if.sv
// Carrier of decoded thermistor zones between zone decoder and register bank
`timescale 1ns/100ps
interface thermistor_zone_if;
  import charger_status_pkg::*;
  logic [ZONE_COUNT-1:0] zone;  // {cold, cool, warm, hot}
  modport producer (output zone);
  modport consumer (input  zone);
endinterface

// File: design/thermistor_zone_decoder.sv
// Decoder from thermistor comparator levels to registered zone bits
`timescale 1ns/100ps
module thermistor_zone_decoder (
  input  wire logic                i_clk,              // 20 MHz clock
  input  wire logic                i_reset_n,          // Async reset
  input  wire logic                i_ts_above_cold,    // V_TS > cold level
  input  wire logic                i_ts_above_cool,    // V_TS > cool level
  input  wire logic                i_ts_below_warm,    // V_TS < warm level
  input  wire logic                i_ts_below_hot,     // V_TS < hot level
  thermistor_zone_if.producer      zones               // Decoded zones
);
  import charger_status_pkg::*;

  typedef struct packed {
    logic [ZONE_COUNT-1:0] zone;
  } zone_state_type;

  zone_state_type state;
  zone_state_type next_state;

  // Zones are made exclusive so software never sees cool and cold at once
  always_comb begin
    next_state = state;
    next_state.zone[3] = i_ts_above_cold;
    next_state.zone[2] = i_ts_above_cool & ~i_ts_above_cold;
    next_state.zone[1] = i_ts_below_warm & ~i_ts_below_hot;
    next_state.zone[0] = i_ts_below_hot;
  end

  // Zone register, live each cycle with no latching
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign zones.zone = state.zone;

  a_cool_excludes_cold: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_ts_above_cold |=> !state.zone[2] && state.zone[3])
    else $error("cool zone set while cold");
  a_warm_excludes_hot: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_ts_below_hot |=> !state.zone[1] && state.zone[0])
    else $error("warm zone set while hot");
endmodule

// File: design/charger_live_status_regs.sv
// Read-only live charger status register bank with charge zone actions
`timescale 1ns/100ps
module charger_live_status_regs (
  input  wire logic       i_clk,                  // 20 MHz clock
  input  wire logic       i_reset_n,              // Async reset, active low
  input  wire logic       i_taper_mode_active,    // CV taper charging
  input  wire logic       i_charge_done,          // Charge terminated
  input  wire logic       i_input_current_limiting_active, // Input limit
  input  wire logic       i_power_path_regulation_active,  // Power path
  input  wire logic       i_input_voltage_regulation_active, // Vin reg
  input  wire logic       i_thermal_regulation_active,     // Die thermal
  input  wire logic       i_vin_above_lockout,    // V_IN > UVLO level
  input  wire logic       i_vin_above_sleep,      // V_IN > V_BAT + offset
  input  wire logic       i_vin_below_overvoltage, // V_IN < OVP level
  input  wire logic       i_input_overvoltage_active,    // Input OVP
  input  wire logic       i_battery_overcurrent_active,  // Battery OCP
  input  wire logic       i_battery_below_lockout_level, // V_BAT < lockout
  input  wire logic       i_ts_above_cold,        // V_TS > cold level
  input  wire logic       i_ts_above_cool,        // V_TS > cool level
  input  wire logic       i_ts_below_warm,        // V_TS < warm level
  input  wire logic       i_ts_below_hot,         // V_TS < hot level
  input  wire logic       i_rd_en,                // Read strobe
  input  wire logic [7:0] i_rd_addr,              // Read offset
  input  wire logic       i_wr_en,                // Write strobe, ignored
  input  wire logic [7:0] i_wr_addr,              // Write offset
  input  wire logic [7:0] i_wr_data,              // Write data
  output logic      [7:0] o_rd_data,              // Read data
  output logic            o_rd_valid,             // Read data valid pulse
  output logic            o_wr_ignored,           // Write dropped pulse
  output logic            o_charge_suspend,       // Stop charging
  output logic            o_charge_current_reduce, // Cut charge current
  output logic            o_charge_voltage_reduce  // Cut regulation voltage
);
  import charger_status_pkg::*;

  typedef struct packed {
    logic [7:0] charge_regulation_status;
    logic [7:0] fault_status_low;  // Non-thermistor fault bits, zones 0
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       wr_ignored;
    logic       charge_suspend;
    logic       charge_current_reduce;
    logic       charge_voltage_reduce;
  } bank_state_type;

  bank_state_type state;
  bank_state_type next_state;
  logic [7:0]     fault_temperature_status;

  thermistor_zone_if zone_link ();

  // Zone decode kept apart so the comparator handling can be reused
  thermistor_zone_decoder u_zone_decoder (
    .i_clk           (i_clk),
    .i_reset_n       (i_reset_n),
    .i_ts_above_cold (i_ts_above_cold),
    .i_ts_above_cool (i_ts_above_cool),
    .i_ts_below_warm (i_ts_below_warm),
    .i_ts_below_hot  (i_ts_below_hot),
    .zones           (zone_link.producer)
  );

  // Full fault register view, zones come already registered
  always_comb begin
    fault_temperature_status = state.fault_status_low;
    fault_temperature_status[THERMISTOR_COLD_ZONE_BIT] = zone_link.zone[3];
    fault_temperature_status[THERMISTOR_COOL_ZONE_BIT] = zone_link.zone[2];
    fault_temperature_status[THERMISTOR_WARM_ZONE_BIT] = zone_link.zone[1];
    fault_temperature_status[THERMISTOR_HOT_ZONE_BIT]  = zone_link.zone[0];
  end

  // Next state: live sampling, read mux and zone actions
  always_comb begin
    next_state = state;
    // Reserved bit 7 stays zero, nothing is held over
    next_state.charge_regulation_status = 8'h00;
    next_state.charge_regulation_status[TAPER_MODE_ACTIVE_BIT] =
      i_taper_mode_active;
    next_state.charge_regulation_status[CHARGE_DONE_BIT] =
      i_charge_done;
    next_state.charge_regulation_status[INPUT_CURRENT_LIMITING_ACTIVE_BIT] =
      i_input_current_limiting_active;
    next_state.charge_regulation_status[POWER_PATH_REGULATION_ACTIVE_BIT] =
      i_power_path_regulation_active;
    next_state.charge_regulation_status[INPUT_VOLTAGE_REGULATION_ACTIVE_BIT] =
      i_input_voltage_regulation_active;
    next_state.charge_regulation_status[THERMAL_REGULATION_ACTIVE_BIT] =
      i_thermal_regulation_active;
    // Power good needs all three input checks at once
    next_state.charge_regulation_status[INPUT_POWER_GOOD_BIT] =
      i_vin_above_lockout & i_vin_above_sleep &
      i_vin_below_overvoltage;
    next_state.fault_status_low = 8'h00;
    next_state.fault_status_low[INPUT_OVERVOLTAGE_ACTIVE_BIT] =
      i_input_overvoltage_active;
    next_state.fault_status_low[BATTERY_OVERCURRENT_ACTIVE_BIT] =
      i_battery_overcurrent_active;
    next_state.fault_status_low[BATTERY_UNDERVOLTAGE_ACTIVE_BIT] =
      i_battery_below_lockout_level;
    // Read answers from the live copy; unmapped offsets read zero
    next_state.rd_valid = i_rd_en;
    if (i_rd_en) begin
      case (i_rd_addr)
        CHARGE_REGULATION_STATUS_OFFSET: begin
          next_state.rd_data = state.charge_regulation_status;
        end
        FAULT_TEMPERATURE_STATUS_OFFSET: begin
          next_state.rd_data = fault_temperature_status;
        end
        default: begin
          next_state.rd_data = UNMAPPED_READ_VALUE;
        end
      endcase
    end
    // No write path exists; a write to a mapped offset is only acknowledged as dropped
    next_state.wr_ignored = i_wr_en &
      ((i_wr_addr == CHARGE_REGULATION_STATUS_OFFSET) |
       (i_wr_addr == FAULT_TEMPERATURE_STATUS_OFFSET)) &
      (i_wr_data == i_wr_data);
    // Zone actions follow the registered zones
    next_state.charge_suspend =
      zone_link.zone[3] | zone_link.zone[0];
    next_state.charge_current_reduce = zone_link.zone[2];
    next_state.charge_voltage_reduce = zone_link.zone[1];
  end

  // Single state register; reset value chosen as zero
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state.charge_regulation_status <= STATUS_RESET_VALUE;
      state.fault_status_low         <= STATUS_RESET_VALUE;
      state.rd_data                  <= 8'h00;
      state.rd_valid                 <= 1'b0;
      state.wr_ignored               <= 1'b0;
      state.charge_suspend           <= 1'b0;
      state.charge_current_reduce    <= 1'b0;
      state.charge_voltage_reduce    <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign o_rd_data               = state.rd_data;
  assign o_rd_valid              = state.rd_valid;
  assign o_wr_ignored            = state.wr_ignored;
  assign o_charge_suspend        = state.charge_suspend;
  assign o_charge_current_reduce = state.charge_current_reduce;
  assign o_charge_voltage_reduce = state.charge_voltage_reduce;

  // Helper: cycles since reset release, saturating at three
  logic [1:0] settle;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      settle <= 2'h0;
    end else if (settle != 2'h3) begin
      settle <= settle + 2'h1;
    end
  end

  sequence s_read_regulation;
    i_rd_en && (i_rd_addr == CHARGE_REGULATION_STATUS_OFFSET) &&
      (settle == 2'h3);
  endsequence
  sequence s_read_fault;
    i_rd_en && (i_rd_addr == FAULT_TEMPERATURE_STATUS_OFFSET) &&
      (settle == 2'h3);
  endsequence

  a_taper_bit_read: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_read_regulation |=>
      o_rd_data[6] == $past(i_taper_mode_active, 2))
    else $error("taper bit does not follow condition");
  a_regulation_bits_read: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_read_regulation |=> o_rd_data[5:1] == $past({i_charge_done,
      i_input_current_limiting_active, i_power_path_regulation_active,
      i_input_voltage_regulation_active, i_thermal_regulation_active}, 2))
    else $error("regulation bits do not follow conditions");
  a_power_good_and: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_read_regulation |=> o_rd_data[0] == $past(i_vin_above_lockout &&
      i_vin_above_sleep && i_vin_below_overvoltage, 2))
    else $error("power good not the and of three checks");
  a_fault_bits_read: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_read_fault |=> {o_rd_data[7], o_rd_data[5]} ==
      $past({i_input_overvoltage_active, i_battery_overcurrent_active}, 2))
    else $error("fault bits do not follow conditions");
  a_battery_lockout_read: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_read_fault |=> o_rd_data[4] == $past(i_battery_below_lockout_level, 2))
    else $error("battery lockout bit wrong");
  a_cold_suspends: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ts_above_cold && settle == 2'h3) |=> ##1 o_charge_suspend)
    else $error("cold zone did not suspend charging");
  a_cool_reduces_current: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (settle == 2'h3) |=> ##1
      o_charge_current_reduce == $past(i_ts_above_cool && !i_ts_above_cold, 2))
    else $error("cool zone current reduction wrong");
  a_warm_reduces_voltage: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (settle == 2'h3) |=> ##1
      o_charge_voltage_reduce == $past(i_ts_below_warm && !i_ts_below_hot, 2))
    else $error("warm zone voltage reduction wrong");
  a_hot_suspends: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ts_below_hot && settle == 2'h3) |=>
      fault_temperature_status[0] ##1 o_charge_suspend)
    else $error("hot zone did not suspend charging");
  a_reserved_read_zero: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (s_read_regulation |=> o_rd_data[7] == 1'b0) and
    (s_read_fault |=> o_rd_data[6] == 1'b0))
    else $error("reserved bit read as one");
endmodule

// File: sim/charger_live_status_regs_tb_top.sv
// Self-checking bench for the live charger status register bank
`timescale 1ns/100ps
module charger_live_status_regs_tb_top;
  import charger_status_pkg::*;
  logic        i_clk;
  logic        i_reset_n;
  logic [15:0] cond;      // Condition inputs, mapped at the instance
  logic        i_rd_en;
  logic [7:0]  i_rd_addr;
  logic        i_wr_en;
  logic [7:0]  i_wr_addr;
  logic [7:0]  i_wr_data;
  logic [7:0]  o_rd_data;
  logic        o_rd_valid;
  logic        o_wr_ignored;
  logic        o_charge_suspend;
  logic        o_charge_current_reduce;
  logic        o_charge_voltage_reduce;
  int          fails;
  int          num_checks;
  int          i;
  logic [3:0]  zt [6] = '{4'h0, 4'h3, 4'h2, 4'hC, 4'h4, 4'h1};

  // cond[6:1] sit at their regulation bit positions to keep expectations short
  charger_live_status_regs dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_taper_mode_active(cond[6]), .i_charge_done(cond[5]),
    .i_input_current_limiting_active(cond[4]),
    .i_power_path_regulation_active(cond[3]),
    .i_input_voltage_regulation_active(cond[2]),
    .i_thermal_regulation_active(cond[1]),
    .i_vin_above_lockout(cond[0]), .i_vin_above_sleep(cond[7]),
    .i_vin_below_overvoltage(cond[8]),
    .i_input_overvoltage_active(cond[9]),
    .i_battery_overcurrent_active(cond[10]),
    .i_battery_below_lockout_level(cond[11]),
    .i_ts_above_cold(cond[12]), .i_ts_above_cool(cond[13]),
    .i_ts_below_warm(cond[14]), .i_ts_below_hot(cond[15]),
    .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr),
    .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_wr_ignored(o_wr_ignored), .o_charge_suspend(o_charge_suspend),
    .o_charge_current_reduce(o_charge_current_reduce),
    .o_charge_voltage_reduce(o_charge_voltage_reduce)
  );

  // 20 MHz clock
  initial i_clk = 1'b0;
  always #25 i_clk = ~i_clk;

  // Verdict and end of run, also reached by a timed-out wait
  task automatic end_sim;
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] g, input logic [7:0] e,
                        input string m);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic check1(input logic g, input logic e, input string m);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: %s got %b exp %b", $time, m, g, e);
    end
  endtask

  // Expected register contents; zones exclusive, cold and hot win
  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    if (a == CHARGE_REGULATION_STATUS_OFFSET)
      return {1'b0, cond[6:1], cond[0] & cond[7] & cond[8]};
    if (a == FAULT_TEMPERATURE_STATUS_OFFSET)
      return {cond[9], 1'b0, cond[10], cond[11], cond[12],
              cond[13] & !cond[12], cond[14] & !cond[15], cond[15]};
    return UNMAPPED_READ_VALUE;
  endfunction

  // Two edges let both the status bits and the zone actions settle
  task automatic set_cond(input logic [15:0] v);
    cond = v;
    repeat (2) @(negedge i_clk);
  endtask

  // One read, bounded wait for the valid pulse, then compare
  task automatic rd_chk(input logic [7:0] a);
    int n;
    i_rd_en = 1'b1;
    i_rd_addr = a;
    @(negedge i_clk);
    i_rd_en = 1'b0;
    for (n = 0; n < 4 && o_rd_valid !== 1'b1; n++) @(negedge i_clk);
    if (n == 4) begin
      fails++;
      $display("mismatch at %0t: no read valid", $time);
      end_sim();
    end
    check8(o_rd_data, exp_reg(a), "read data");
  endtask

  // Write attempt; the ignore pulse lasts exactly one cycle
  task automatic wr(input logic [7:0] a, input logic ign);
    i_wr_en = 1'b1;
    i_wr_addr = a;
    i_wr_data = 8'hFF;
    @(negedge i_clk);
    i_wr_en = 1'b0;
    check1(o_wr_ignored, ign, "write pulse");
    @(negedge i_clk);
    check1(o_wr_ignored, 1'b0, "write pulse width");
  endtask

  task automatic act_chk;
    check1(o_charge_suspend, cond[12] | cond[15], "suspend");
    check1(o_charge_current_reduce, cond[13] & !cond[12], "current");
    check1(o_charge_voltage_reduce, cond[14] & !cond[15], "voltage");
  endtask

  // Main sequence, all inputs moved on the falling edge
  initial begin
    fails = 0;
    num_checks = 0;
    cond = 16'h0000;
    i_rd_en = 1'b0;
    i_rd_addr = 8'h00;
    i_wr_en = 1'b0;
    i_wr_addr = 8'h00;
    i_wr_data = 8'h00;
    i_reset_n = 1'b0;
    repeat (5) @(negedge i_clk);
    check8(o_rd_data, STATUS_RESET_VALUE, "reset data");
    i_reset_n = 1'b1;
    repeat (2) @(negedge i_clk);
    rd_chk(CHARGE_REGULATION_STATUS_OFFSET);
    for (i = 1; i <= 6; i++) begin
      set_cond(16'h0001 << i);
      rd_chk(CHARGE_REGULATION_STATUS_OFFSET);
    end
    // Every combination of the three input checks, others busy
    for (i = 0; i < 8; i++) begin
      set_cond({7'h00, i[2], i[1], 6'h2A, i[0]});
      rd_chk(CHARGE_REGULATION_STATUS_OFFSET);
    end
    for (i = 9; i <= 11; i++) begin
      set_cond(16'h0001 << i);
      rd_chk(FAULT_TEMPERATURE_STATUS_OFFSET);
    end
    for (i = 0; i < 6; i++) begin
      set_cond({zt[i], 12'h000});
      rd_chk(FAULT_TEMPERATURE_STATUS_OFFSET);
      act_chk();
    end
    // Live values must drop as soon as the cause goes away
    set_cond(16'h3FFF);
    rd_chk(FAULT_TEMPERATURE_STATUS_OFFSET);
    set_cond(16'h0000);
    rd_chk(FAULT_TEMPERATURE_STATUS_OFFSET);
    rd_chk(CHARGE_REGULATION_STATUS_OFFSET);
    set_cond(16'h5A5F);
    wr(CHARGE_REGULATION_STATUS_OFFSET, 1'b1);
    wr(FAULT_TEMPERATURE_STATUS_OFFSET, 1'b1);
    wr(8'h02, 1'b0);
    rd_chk(CHARGE_REGULATION_STATUS_OFFSET);
    rd_chk(FAULT_TEMPERATURE_STATUS_OFFSET);
    rd_chk(8'h02);
    rd_chk(8'hFF);
    // Back-to-back reads; each answer follows one cycle after its request, valid drops after the last
    i_rd_en = 1'b1;
    i_rd_addr = CHARGE_REGULATION_STATUS_OFFSET;
    @(negedge i_clk);
    i_rd_addr = FAULT_TEMPERATURE_STATUS_OFFSET;
    check8(o_rd_data, exp_reg(CHARGE_REGULATION_STATUS_OFFSET),
           "b2b 0");
    @(negedge i_clk);
    i_rd_en = 1'b0;
    check8(o_rd_data, exp_reg(FAULT_TEMPERATURE_STATUS_OFFSET),
           "b2b 1");
    check1(o_rd_valid, 1'b1, "b2b valid");
    @(negedge i_clk);
    check1(o_rd_valid, 1'b0, "valid width");
    // Reset in mid-run with the cold zone present
    set_cond(16'h3000);
    i_reset_n = 1'b0;
    @(negedge i_clk);
    check1(o_charge_suspend, 1'b0, "suspend in reset");
    i_reset_n = 1'b1;
    repeat (2) @(negedge i_clk);
    act_chk();
    rd_chk(FAULT_TEMPERATURE_STATUS_OFFSET);
    end_sim();
  end
endmodule
